// *** verilog/press_auto_pkg.sv ***
package press_auto_pkg;

	// Logic cycle rate and millisecond time base.
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned TICK_MS        = 1;
	localparam int unsigned MS_PER_S       = 1000;
	localparam int unsigned TICK_CYCLES    = (CLK_HZ / MS_PER_S) * TICK_MS;

	// Rearm pulse limits, each in its own unit; only the maximum is also given in ticks.
	localparam int unsigned REARM_MIN_SHORT_MS = 100;
	localparam int unsigned REARM_MIN_LONG_MS  = 350;
	localparam int unsigned REARM_MAX_S        = 30;
	localparam int unsigned REARM_MAX_TICKS    = (REARM_MAX_S * MS_PER_S) / TICK_MS;
	localparam int unsigned PULSE_CNT_W        = 16;

	// Values after reset.
	localparam logic RST_DRIVE   = 1'h0;
	localparam logic RST_PENDING = 1'h0;
	localparam logic RST_LEVEL   = 1'h0;

	// Halt-request mode encoding.
	localparam logic MODE_TRIGGER_LOW = 1'h0;
	localparam logic MODE_HALT_HIGH   = 1'h1;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'h0,
		ST_RUN      = 2'h1,
		ST_STOP_PND = 2'h3
	} drive_state_t;

endpackage : press_auto_pkg

// *** verilog/rearm_pulse_check.sv ***
module rearm_pulse_check
	import press_auto_pkg::*;
#(
	parameter int unsigned CNT_W     = PULSE_CNT_W,
	parameter int unsigned MAX_TICKS = REARM_MAX_TICKS
)(
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Time base and selection.
	input  wire logic tick_i,
	input  wire logic long_min_i,
	// Rearm level and result.
	input  wire logic rearm_i,
	output logic      valid_o
);

	logic             level_q, level_d;
	logic             armed_q, armed_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             valid_q, valid_d;
	logic [CNT_W-1:0] min_ticks;
	logic [CNT_W-1:0] max_ticks;

	assign min_ticks = long_min_i ? CNT_W'(REARM_MIN_LONG_MS / TICK_MS)
	                              : CNT_W'(REARM_MIN_SHORT_MS / TICK_MS);
	assign max_ticks = CNT_W'(MAX_TICKS);

	////////////////////////////////////////////////////////////////////////////
	// The High phase is timed in whole ticks and saturates one above the limit.
	always_comb
	begin
		level_d = rearm_i;
		armed_d = armed_q;
		cnt_d   = cnt_q;
		valid_d = 1'h0;
		if (!rearm_i && !level_q)
		begin
			armed_d = 1'h1;
		end
		if (rearm_i && !level_q)
		begin
			cnt_d = '0;
		end
		else if (rearm_i && tick_i && cnt_q <= max_ticks)
		begin
			cnt_d = cnt_q + CNT_W'(1);
		end
		if (!rearm_i && level_q)
		begin
			valid_d = armed_q && cnt_q >= min_ticks && cnt_q <= max_ticks;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			level_q <= RST_LEVEL;
			armed_q <= 1'h0;
			cnt_q   <= '0;
			valid_q <= 1'h0;
		end
		else
		begin
			level_q <= level_d;
			armed_q <= armed_d;
			cnt_q   <= cnt_d;
			valid_q <= valid_d;
		end
	end

	assign valid_o = valid_q;

endmodule : rearm_pulse_check

// *** verilog/press_auto_interlock.sv ***
// Overview of operation
// - Trigger rising edge raises permit when unhindered.
// - Halt-high mode: High halt forces permit Low.
// - Trigger-low mode: halt input is ignored.
// - Static permit Low drops permit at once.
// - Start permit, if used, gates every rise.
// - Start permit unchecked while permit is High.
// - Cycle-end input marks top dead centre.
// - Rearm disabled: restart needs no rearm pulse.
// - Rearm enabled: timed Low-High-Low pulse re-allows rise.
// - Rearm-pending output High while awaiting pulse.
// - Trigger-low mode: trigger Low drops permit at the next stop position.
// - Upstroke option also allows stops on upstroke.
module press_auto_interlock
	import press_auto_pkg::*;
#(
	parameter int unsigned TICK_CNT  = TICK_CYCLES,
	parameter int unsigned MAX_TICKS = REARM_MAX_TICKS
)(
	// Clock and reset.
	input  wire logic CLK_SYS_I,
	input  wire logic RST_I,
	// Process inputs.
	input  wire logic TRIGGER_I,
	input  wire logic HALT_I,
	input  wire logic STATIC_PERMIT_I,
	input  wire logic START_PERMIT_I,
	input  wire logic CYCLE_END_I,
	input  wire logic UPSTROKE_I,
	input  wire logic REARM_I,
	// Configuration.
	input  wire logic HALT_MODE_I,
	input  wire logic START_PERMIT_EN_I,
	input  wire logic UPSTROKE_EN_I,
	input  wire logic REARM_EN_I,
	input  wire logic REARM_LONG_MIN_I,
	// Outputs.
	output logic      DRIVE_PERMIT_O,
	output logic      REARM_PENDING_O
);

	localparam int unsigned TICK_W = $clog2(TICK_CNT + 1);

	logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic              tick_q, tick_d;
	logic              trig_q, trig_d;
	drive_state_t      state_q, state_d;
	logic              drive_q, drive_d;
	logic              pend_q, pend_d;
	logic              rearm_valid;
	logic              hold_ok;
	logic              start_ok;
	logic              stop_pos;
	logic              stop_req;

	////////////////////////////////////////////////////////////////////////////
	// Millisecond time base.
	always_comb
	begin
		tick_d     = 1'h0;
		tick_cnt_d = tick_cnt_q + TICK_W'(1);
		if (tick_cnt_q == TICK_W'(TICK_CNT - 1))
		begin
			tick_cnt_d = '0;
			tick_d     = 1'h1;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'h0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
		end
	end

	rearm_pulse_check #(
		.CNT_W     (PULSE_CNT_W),
		.MAX_TICKS (MAX_TICKS)
	) u_rearm (
		.clk_i      (CLK_SYS_I),
		.rst_i      (RST_I),
		.tick_i     (tick_q),
		.long_min_i (REARM_LONG_MIN_I),
		.rearm_i    (REARM_I),
		.valid_o    (rearm_valid)
	);

	////////////////////////////////////////////////////////////////////////////
	// Trigger edge detector; it resets Low, so a High trigger at release is an edge.
	always_comb
	begin
		trig_d = TRIGGER_I;
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			trig_q <= RST_LEVEL;
		end
		else
		begin
			trig_q <= trig_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stop causes and start conditions.
	always_comb
	begin
		// Halt only counts in halt-high mode.
		hold_ok  = STATIC_PERMIT_I && !(HALT_MODE_I == MODE_HALT_HIGH && HALT_I);
		start_ok = TRIGGER_I && !trig_q && hold_ok && !pend_q
		           && (!START_PERMIT_EN_I || START_PERMIT_I);
		stop_pos = CYCLE_END_I || (UPSTROKE_EN_I && UPSTROKE_I);
		stop_req = HALT_MODE_I == MODE_TRIGGER_LOW && !TRIGGER_I;
	end

	////////////////////////////////////////////////////////////////////////////
	// Drive permit state machine.
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (start_ok)
				begin
					state_d = ST_RUN;
				end
			end
			ST_RUN:
			begin
				// Start permit is no longer looked at here.
				if (!hold_ok)
				begin
					state_d = ST_IDLE;
				end
				else if (stop_req)
				begin
					state_d = stop_pos ? ST_IDLE : ST_STOP_PND;
				end
			end
			ST_STOP_PND:
			begin
				if (!hold_ok)
				begin
					state_d = ST_IDLE;
				end
				else if (!stop_req)
				begin
					state_d = ST_RUN;
				end
				else if (stop_pos)
				begin
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
		// The permit follows the next state, so the output adds no cycle of delay.
		drive_d = state_d != ST_IDLE;
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			state_q <= ST_IDLE;
			drive_q <= RST_DRIVE;
		end
		else
		begin
			state_q <= state_d;
			drive_q <= drive_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rearm interlock; a stop in the same cycle as a valid pulse keeps it set.
	always_comb
	begin
		pend_d = pend_q;
		if (!REARM_EN_I)
		begin
			pend_d = 1'h0;
		end
		else if (drive_q && !drive_d)
		begin
			pend_d = 1'h1;
		end
		else if (rearm_valid)
		begin
			pend_d = 1'h0;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			pend_q <= RST_PENDING;
		end
		else
		begin
			pend_q <= pend_d;
		end
	end

	assign DRIVE_PERMIT_O  = drive_q;
	assign REARM_PENDING_O = pend_q;

endmodule : press_auto_interlock

// *** bench/press_partner.sv ***
module press_partner (
	input  wire logic clk_i,
	input  wire logic run_i,
	output logic      top_o,
	output logic      up_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pos_q = 4'h1;
	// The crank only turns while the drive is permitted.
	always @(posedge clk_i) if (run_i) pos_q <= pos_q + 4'h1;
	assign top_o = pos_q == 4'h0;
	assign up_o  = pos_q[3];
endmodule : press_partner

// *** bench/press_auto_interlock_checker.sv ***
module press_auto_interlock_checker
	import press_auto_pkg::*;
(
	input wire logic CLK_SYS_I, RST_I, TRIGGER_I, HALT_I, STATIC_PERMIT_I,
	input wire logic START_PERMIT_I, CYCLE_END_I, UPSTROKE_I, REARM_I, HALT_MODE_I,
	input wire logic START_PERMIT_EN_I, UPSTROKE_EN_I, REARM_EN_I, REARM_LONG_MIN_I,
	input wire logic DRIVE_PERMIT_O, REARM_PENDING_O
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic dp = DRIVE_PERMIT_O;
	wire logic rp = REARM_PENDING_O;
	wire logic hs = HALT_MODE_I && HALT_I;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	chk_static_drop: assert property (!STATIC_PERMIT_I |=> !dp)
		else $error("permit held without static permit");
	chk_halt_stop: assert property (hs |=> !dp)
		else $error("permit held during halt");
	chk_rise_cause: assert property ($rose(dp) |-> $past(TRIGGER_I) && !$past(hs) && !$past(rp))
		else $error("permit rose without cause");
	chk_start_gate: assert property ($rose(dp) |-> !$past(START_PERMIT_EN_I) || $past(START_PERMIT_I))
		else $error("permit rose without start permit");
	chk_start_free: assert property (dp && STATIC_PERMIT_I && (HALT_MODE_I ? !HALT_I : TRIGGER_I) |=> dp)
		else $error("permit dropped without stop cause");
	chk_top_stop: assert property (!HALT_MODE_I && dp && !TRIGGER_I && (CYCLE_END_I || UPSTROKE_EN_I && UPSTROKE_I) |=> !dp)
		else $error("no stop at stop position");
	chk_pend_set: assert property (REARM_EN_I && $fell(dp) |-> rp)
		else $error("no rearm pending after stop");
	chk_pend_block: assert property (rp |=> !$rose(dp))
		else $error("permit rose while rearm pending");
	chk_no_rearm: assert property (!REARM_EN_I |=> !rp)
		else $error("rearm pending while disabled");
	cover property ($rose(dp));
	cover property ($fell(rp));
	cover property ($fell(dp) && !HALT_MODE_I);
endmodule : press_auto_interlock_checker
bind press_auto_interlock press_auto_interlock_checker u_checker (
	.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .TRIGGER_I(TRIGGER_I), .HALT_I(HALT_I),
	.STATIC_PERMIT_I(STATIC_PERMIT_I), .START_PERMIT_I(START_PERMIT_I),
	.CYCLE_END_I(CYCLE_END_I), .UPSTROKE_I(UPSTROKE_I), .REARM_I(REARM_I),
	.HALT_MODE_I(HALT_MODE_I), .START_PERMIT_EN_I(START_PERMIT_EN_I),
	.UPSTROKE_EN_I(UPSTROKE_EN_I), .REARM_EN_I(REARM_EN_I),
	.REARM_LONG_MIN_I(REARM_LONG_MIN_I), .DRIVE_PERMIT_O(DRIVE_PERMIT_O),
	.REARM_PENDING_O(REARM_PENDING_O));

// *** bench/test_press_auto_interlock.sv ***
module test_press_auto_interlock;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, trg, halt, stat, sp, rearm, hm, spe, upe, rae, lm, dp, rp, ce, up;
	int error_cnt = 0, n_compared = 0, cyc = 0;
	logic [5:0] row [6] = '{6'h2B, 6'h3A, 6'h1B, 6'h22, 6'h2C, 6'h2F};
	int plen [5] = '{50, 130, 200, 380, 420};
	logic [4:0] pm = 5'h0C, pe = 5'h15;
	always #4 clk = ~clk;
	press_auto_interlock #(.TICK_CNT(10), .MAX_TICKS(400)) uut (
		.CLK_SYS_I(clk), .RST_I(rst), .TRIGGER_I(trg), .HALT_I(halt), .STATIC_PERMIT_I(stat),
		.START_PERMIT_I(sp), .CYCLE_END_I(ce), .UPSTROKE_I(up), .REARM_I(rearm),
		.HALT_MODE_I(hm), .START_PERMIT_EN_I(spe), .UPSTROKE_EN_I(upe), .REARM_EN_I(rae),
		.REARM_LONG_MIN_I(lm), .DRIVE_PERMIT_O(dp), .REARM_PENDING_O(rp));
	press_partner far (.clk_i(clk), .run_i(dp), .top_o(ce), .up_o(up));
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cy
	task automatic chk(input string nm, input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s exp %b got %b", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic start();
		@(posedge clk) trg <= 1'h0;
		@(posedge clk) trg <= 1'h1;
		cy(2);
	endtask : start
	task automatic drop();
		@(posedge clk) stat <= 1'h0;
		@(posedge clk) stat <= 1'h1;
		cy(1);
	endtask : drop
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	initial
	begin
		{clk, trg, halt, rearm, spe, upe, rae, lm} = 8'h00;
		{rst, stat, sp, hm} = 4'hF;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		cy(1);
		chk("dp", dp, 1'h0);
		chk("rp", rp, 1'h0);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk) {hm, halt, stat, spe, sp} <= row[i][5:1];
			start();
			chk("dp", dp, row[i][0]);
			drop();
			chk("dp", dp, 1'h0);
		end
		@(posedge clk) {hm, halt, spe} <= 3'h3;
		for (int j = 0; j < 2; j++)
		begin
			@(posedge clk) {upe, sp} <= {1'(j), 1'h1};
			start();
			@(posedge clk) sp <= 1'h0;
			cy(3);
			chk("dp", dp, 1'h1);
			@(posedge clk) trg <= 1'h0;
			for (int k = 0; k < 40 && dp; k++) cy(1);
			chk("dp", dp, 1'h0);
			chk("stop_pos", far.pos_q == (j == 0 ? 4'h1 : 4'h9), 1'h1);
		end
		@(posedge clk) {hm, halt, spe, rae} <= 4'h9;
		start();
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk) lm <= pm[i];
			drop();
			chk("rp", rp, 1'h1);
			@(posedge clk) rearm <= 1'h1;
			repeat (plen[i] * 10) @(posedge clk);
			rearm <= 1'h0;
			cy(4);
			chk("rp", rp, pe[i]);
			start();
			chk("dp", dp, !pe[i]);
		end
		@(posedge clk) rae <= 1'h0;
		cy(2);
		chk("rp", rp, 1'h0);
		start();
		chk("dp", dp, 1'h1);
		end_sim();
	end
endmodule : test_press_auto_interlock
